// ===== rtl/smf_frame_ctrl.sv
// Manual-mode frame composer for a multi-line serial flash, APB slave side
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "smf_map.svh"
module smf_frame_ctrl import smf_pkg::*; (
   // APB clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Flash link
   input wire logic link_clk,
   input wire logic [3:0] flash_io_in,
   output smf_io_t flash_io,
   output logic flash_clk_gate,
   output logic flash_select_line_n
);
   // Software-visible state, pclk domain
   smf_phase_cfg_t manual_phase_enable_reg; // Phase enables and widths
   smf_ctrl_t ctrl; // Hold, read/write, DDR, dummy count
   logic [7:0] cmd_code; // Command byte
   logic [7:0] ocmd_code; // Optional command byte
   logic [31:0] addr; // Flash address
   logic [31:0] opt; // Option bytes three..zero
   logic [31:0] wdata0; // First write word
   logic [31:0] wdata1; // Second write word, DDR only
   logic go_tgl; // Toggles once per started frame
   logic done_s1; // Done toggle, first sync stage
   logic done_s2; // Done toggle, second sync stage
   logic busy; // Frame in flight
   logic setup; // APB setup cycle
   logic wr_acc; // APB write access phase
   logic hit; // Address maps a register
   logic [31:0] rd_word; // Read mux output
   // Link domain state
   logic lrst_n1; // Reset release, first stage
   logic lrst_n; // Reset of the link domain
   logic go_s1; // Start toggle, first sync stage
   logic go_s2; // Start toggle, second sync stage
   logic go_s3; // Start toggle, edge detect
   logic [3:0] in_s1; // Data pins, first sync stage
   logic [3:0] in_s2; // Data pins, second sync stage
   smf_lk_state_t state; // Frame sequencer
   smf_lk_state_t nx; // Phase that follows the current one
   logic [63:0] sh; // Outgoing shift register
   logic [6:0] cyc; // Cycles left in phase
   logic quad; // Current phase on four lines
   logic drive; // Current phase drives the lines
   logic [63:0] rx; // Incoming shift register
   logic [6:0] dlen; // Data phase length in bits
   logic cap_d1; // Capture enable, lagging pin sync
   logic cap_d2; // Capture enable, aligned to in_s2
   logic capq_d1; // Capture width, lagging
   logic capq_d2; // Capture width, aligned
   logic [1:0] tail; // Cycles left before done
   logic [31:0] rdata0; // First read word
   logic [31:0] rdata1; // Second read word
   logic done_tgl; // Toggles once per finished frame
   logic [5:0] en; // Phase enable vector, frame order
   logic [63:0] ld_val; // Load value for phase nx
   logic [6:0] ld_bits; // Bits in phase nx
   logic [6:0] ld_cyc; // Cycles in phase nx
   logic ld_quad; // Phase nx on four lines
   logic [2:0] opt_n; // Option byte count
   logic [6:0] data_bits; // Data phase bits

   // Zero-wait slave; data is set up in the setup cycle
   assign pready = 1'b1;
   assign setup = psel & ~penable;
   assign wr_acc = psel & penable & pwrite;
   assign busy = go_tgl ^ done_s2;

   // Register decode and read mux
   always_comb begin
      hit = paddr[1:0] == 2'b00;
      rd_word = 32'h0;
      unique case (paddr)
         `SMF_CTRL_OFS: begin
            rd_word[`SMF_CTRL_CFG_MSB:`SMF_CTRL_CFG_LSB] = ctrl;
            rd_word[`SMF_CTRL_BUSY_BIT] = busy;
         end
         `SMF_PHASE_OFS: rd_word = manual_phase_enable_reg;
         `SMF_CMD_OFS: rd_word = {8'h0, cmd_code, 8'h0, ocmd_code};
         `SMF_ADDR_OFS: rd_word = addr;
         `SMF_OPT_OFS: rd_word = opt;
         `SMF_WDATA0_OFS: rd_word = wdata0;
         `SMF_WDATA1_OFS: rd_word = wdata1;
         `SMF_RDATA0_OFS: rd_word = rdata0;
         `SMF_RDATA1_OFS: rd_word = rdata1;
         default: hit = 1'b0;
      endcase
   end

   // Read data and error latched in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata <= pwrite ? 32'h0 : rd_word;
         pslverr <= ~hit;
      end
   end

   // Register writes; configuration is frozen while a frame runs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         manual_phase_enable_reg <= `SMF_RESET_WORD;
         ctrl <= '0;
         cmd_code <= 8'h0;
         ocmd_code <= 8'h0;
         addr <= `SMF_RESET_WORD;
         opt <= `SMF_RESET_WORD;
         wdata0 <= `SMF_RESET_WORD;
         wdata1 <= `SMF_RESET_WORD;
         go_tgl <= 1'b0;
      end else if (wr_acc && hit && !busy) begin
         unique case (paddr)
            `SMF_CTRL_OFS: begin
               ctrl <= pwdata[`SMF_CTRL_CFG_MSB:`SMF_CTRL_CFG_LSB];
               // Start request crosses as a toggle
               if (pwdata[`SMF_CTRL_START_BIT]) begin
                  go_tgl <= ~go_tgl;
               end
            end
            `SMF_PHASE_OFS: manual_phase_enable_reg <= pwdata & `SMF_PHASE_RSV_MASK;
            `SMF_CMD_OFS: begin
               cmd_code <= pwdata[23:16];
               ocmd_code <= pwdata[7:0];
            end
            `SMF_ADDR_OFS: addr <= pwdata;
            `SMF_OPT_OFS: opt <= pwdata;
            `SMF_WDATA0_OFS: wdata0 <= pwdata;
            `SMF_WDATA1_OFS: wdata1 <= pwdata;
            default: ;
         endcase
      end
   end

   // Done toggle back into pclk
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_s1 <= 1'b0;
         done_s2 <= 1'b0;
      end else begin
         done_s1 <= done_tgl;
         done_s2 <= done_s1;
      end
   end

   // Link reset: asynchronous assert, synchronous release
   always_ff @(posedge link_clk or negedge presetn) begin
      if (!presetn) begin
         lrst_n1 <= 1'b0;
         lrst_n <= 1'b0;
      end else begin
         lrst_n1 <= 1'b1;
         lrst_n <= lrst_n1;
      end
   end

   // Start toggle and data pins into link domain
   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         go_s1 <= 1'b0;
         go_s2 <= 1'b0;
         go_s3 <= 1'b0;
         in_s1 <= 4'h0;
         in_s2 <= 4'h0;
      end else begin
         go_s1 <= go_tgl;
         go_s2 <= go_s1;
         go_s3 <= go_s2;
         in_s1 <= flash_io_in;
         in_s2 <= in_s1;
      end
   end

   // Option byte count and data length decode
   always_comb begin
      unique case (manual_phase_enable_reg.opt_en)
         `SMF_OPDE_3: opt_n = 3'd1;
         `SMF_OPDE_32: opt_n = 3'd2;
         `SMF_OPDE_321: opt_n = 3'd3;
         `SMF_OPDE_3210: opt_n = 3'd4;
         default: opt_n = 3'd0;
      endcase
      unique case (manual_phase_enable_reg.data_en)
         `SMF_SPIDE_8: data_bits = 7'd8;
         `SMF_SPIDE_16: data_bits = 7'd16;
         `SMF_SPIDE_32: data_bits = 7'd32;
         default: data_bits = 7'd0;
      endcase
      if (ctrl.data_ddr) begin
         data_bits = data_bits << 1;
      end
   end

   // Enables in frame order; data needs read or write enabled
   always_comb begin
      en[0] = manual_phase_enable_reg.cmd_en;
      en[1] = manual_phase_enable_reg.ocmd_en;
      en[2] = manual_phase_enable_reg.addr_en == `SMF_ADE_24 ||
              manual_phase_enable_reg.addr_en == `SMF_ADE_32;
      en[3] = opt_n != 3'd0;
      en[4] = manual_phase_enable_reg.dummy_en;
      en[5] = data_bits != 7'd0 && (ctrl.rd_en || ctrl.wr_en);
   end

   // First enabled phase after the current one, else the tail
   always_comb begin
      nx = LK_TAIL;
      for (int i = 5; i >= 0; i--) begin
         if (en[i] && i >= int'(state)) begin
            nx = smf_lk_state_t'(3'(i + 1));
         end
      end
   end

   // Shift value, length and width of phase nx
   always_comb begin
      ld_val = 64'h0;
      ld_bits = 7'd0;
      ld_quad = 1'b0;
      unique case (nx)
         LK_CMD: begin
            ld_val = {cmd_code, 56'h0};
            ld_bits = 7'd8;
            ld_quad = manual_phase_enable_reg.cmd_w == `SMF_W_4LINE;
         end
         LK_OCMD: begin
            ld_val = {ocmd_code, 56'h0};
            ld_bits = 7'd8;
            ld_quad = manual_phase_enable_reg.ocmd_w == `SMF_W_4LINE;
         end
         LK_ADDR: begin
            if (manual_phase_enable_reg.addr_en == `SMF_ADE_32) begin
               ld_val = {addr, 32'h0};
               ld_bits = 7'd32;
            end else begin
               ld_val = {addr[23:0], 40'h0};
               ld_bits = 7'd24;
            end
            ld_quad = manual_phase_enable_reg.addr_w == `SMF_W_4LINE;
         end
         LK_OPT: begin
            ld_val = {opt, 32'h0};
            ld_bits = {1'b0, opt_n, 3'b000};
            ld_quad = manual_phase_enable_reg.opt_w == `SMF_W_4LINE;
         end
         LK_DUMMY: ld_bits = 7'(ctrl.dummy_cnt) + 7'd1;
         LK_DATA: begin
            ld_val = {wdata0, wdata1};
            ld_bits = data_bits;
            ld_quad = manual_phase_enable_reg.data_w == `SMF_W_4LINE;
         end
         LK_IDLE, LK_TAIL: ;
      endcase
      ld_cyc = ld_quad ? ld_bits >> 2 : ld_bits;
   end

   // Frame sequencer, one phase after another under one select
   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         state <= LK_IDLE;
         sh <= 64'h0;
         cyc <= 7'd0;
         quad <= 1'b0;
         drive <= 1'b0;
         dlen <= 7'd0;
         tail <= 2'd0;
      end else begin
         unique case (state)
            LK_IDLE: if (go_s2 ^ go_s3) begin
               state <= nx;
               tail <= `SMF_TAIL_CYC;
            end
            LK_TAIL: if (tail == 2'd1) begin
               state <= LK_IDLE;
            end else begin
               tail <= tail - 2'd1;
            end
            default: if (cyc == 7'd1) begin
               state <= nx;
            end else begin
               sh <= quad ? sh << 4 : sh << 1;
               cyc <= cyc - 7'd1;
            end
         endcase
         // Load the next phase whenever the sequencer leaves idle or a phase state
         if ((state == LK_IDLE && (go_s2 ^ go_s3)) ||
             (state != LK_IDLE && state != LK_TAIL && cyc == 7'd1)) begin
            sh <= ld_val;
            cyc <= ld_cyc;
            quad <= ld_quad;
            drive <= nx != LK_DUMMY && (nx != LK_DATA || ctrl.wr_en);
            if (nx == LK_DATA) begin
               dlen <= ld_bits;
            end
         end
      end
   end

   // Read capture, delayed to match the pin synchroniser
   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         cap_d1 <= 1'b0;
         cap_d2 <= 1'b0;
         capq_d1 <= 1'b0;
         capq_d2 <= 1'b0;
         rx <= 64'h0;
      end else begin
         cap_d1 <= state == LK_DATA && ctrl.rd_en;
         cap_d2 <= cap_d1;
         capq_d1 <= quad;
         capq_d2 <= capq_d1;
         if (state == LK_IDLE) begin
            rx <= 64'h0;
         end else if (cap_d2) begin
            rx <= capq_d2 ? {rx[59:0], in_s2} : {rx[62:0], in_s2[1]};
         end
      end
   end

   // Completion: read words, done toggle, select line
   always_ff @(posedge link_clk or negedge lrst_n) begin
      if (!lrst_n) begin
         rdata0 <= 32'h0;
         rdata1 <= 32'h0;
         done_tgl <= 1'b0;
         flash_select_line_n <= 1'b1;
      end else if (state == LK_IDLE && (go_s2 ^ go_s3)) begin
         flash_select_line_n <= 1'b0;
      end else if (state == LK_TAIL && tail == 2'd1) begin
         {rdata0, rdata1} <= rx << (7'd64 - dlen);
         done_tgl <= ~done_tgl;
         if (!ctrl.sel_hold) begin
            flash_select_line_n <= 1'b1;
         end
      end
   end

   // Pin drive from the shift register
   always_comb begin
      flash_clk_gate = state != LK_IDLE && state != LK_TAIL;
      flash_io.dout = quad ? sh[63:60] : {3'b000, sh[63]};
      flash_io.oe = 4'h0;
      if (flash_clk_gate && drive) begin
         flash_io.oe = quad ? 4'hf : 4'h1;
      end
   end
endmodule : smf_frame_ctrl

// ===== rtl/smf_map.svh
// Register offsets, field positions and encodings of the manual frame controller
`ifndef SMF_MAP_SVH
`define SMF_MAP_SVH
`define SMF_CTRL_OFS 8'h00
`define SMF_PHASE_OFS 8'h04
`define SMF_CMD_OFS 8'h08
`define SMF_ADDR_OFS 8'h0c
`define SMF_OPT_OFS 8'h10
`define SMF_WDATA0_OFS 8'h14
`define SMF_WDATA1_OFS 8'h18
`define SMF_RDATA0_OFS 8'h1c
`define SMF_RDATA1_OFS 8'h20
`define SMF_CTRL_START_BIT 0
`define SMF_CTRL_CFG_LSB 1
`define SMF_CTRL_CFG_MSB 7
`define SMF_CTRL_BUSY_BIT 16
`define SMF_PHASE_RSV_MASK 32'hf333_dfff
`define SMF_RESET_WORD 32'h0000_0000
`define SMF_W_1LINE 2'b00
`define SMF_W_4LINE 2'b10
`define SMF_ADE_24 4'h7
`define SMF_ADE_32 4'hf
`define SMF_OPDE_3 4'h8
`define SMF_OPDE_32 4'hc
`define SMF_OPDE_321 4'he
`define SMF_OPDE_3210 4'hf
`define SMF_SPIDE_8 4'h8
`define SMF_SPIDE_16 4'hc
`define SMF_SPIDE_32 4'hf
`define SMF_TAIL_CYC 2'd3
`endif

// ===== rtl/smf_pkg.sv
// Types of the manual frame controller
package smf_pkg;
   // Layout of the phase enable register
   typedef struct packed {
      logic [1:0] cmd_w;
      logic [1:0] ocmd_w;
      logic [1:0] rsv0;
      logic [1:0] addr_w;
      logic [1:0] rsv1;
      logic [1:0] opt_w;
      logic [1:0] rsv2;
      logic [1:0] data_w;
      logic dummy_en;
      logic cmd_en;
      logic rsv3;
      logic ocmd_en;
      logic [3:0] addr_en;
      logic [3:0] opt_en;
      logic [3:0] data_en;
   } smf_phase_cfg_t;
   // Control fields of the control register
   typedef struct packed {
      logic [2:0] dummy_cnt;
      logic data_ddr;
      logic wr_en;
      logic rd_en;
      logic sel_hold;
   } smf_ctrl_t;
   // Driven side of the four flash data lines
   typedef struct packed {
      logic [3:0] dout;
      logic [3:0] oe;
   } smf_io_t;
   // Link-side frame sequencer states, in frame order
   typedef enum logic [2:0] {
      LK_IDLE, LK_CMD, LK_OCMD, LK_ADDR, LK_OPT, LK_DUMMY, LK_DATA, LK_TAIL
   } smf_lk_state_t;
endpackage : smf_pkg

// ===== tb/smf_frame_checker.sv
// Port assertions of the manual frame controller
`timescale 1ns/1ps
module smf_frame_checker import smf_pkg::*; (
   // APB side
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Flash side
   input wire logic link_clk,
   input wire logic [3:0] flash_io_in,
   input wire smf_io_t flash_io,
   input wire logic flash_clk_gate,
   input wire logic flash_select_line_n
);
   // Closing tail: select low, clock gated off
   sequence tail_s;
      (!flash_select_line_n && !flash_clk_gate) [*3];
   endsequence
   // APB access cycle
   sequence acc_s;
      psel && penable;
   endsequence
   gate_in_select_a: assert property (@(posedge link_clk) disable iff (!presetn)
      flash_clk_gate |-> !flash_select_line_n) else $error("clock outside select");
   tail_hold_a: assert property (@(posedge link_clk) disable iff (!presetn)
      $past(flash_clk_gate) && !flash_clk_gate |-> tail_s) else $error("short frame tail");
   oe_codes_a: assert property (@(posedge link_clk) disable iff (!presetn)
      flash_io.oe inside {4'h0, 4'h1, 4'hf}) else $error("bad line enable");
   oe_gated_a: assert property (@(posedge link_clk) disable iff (!presetn)
      flash_io.oe != 4'h0 |-> flash_clk_gate) else $error("drive without clock");
   one_line_a: assert property (@(posedge link_clk) disable iff (!presetn)
      flash_io.oe == 4'h1 |-> flash_io.dout[3:1] == 3'h0) else $error("stray line data");
   sel_rise_a: assert property (@(posedge link_clk) disable iff (!presetn)
      !$past(flash_select_line_n) && flash_select_line_n |-> !$past(flash_clk_gate, 3))
      else $error("early release");
   err_unaligned_a: assert property (@(posedge pclk) disable iff (!presetn)
      acc_s ##0 (paddr[1:0] != 2'b00) |-> pslverr) else $error("unaligned not refused");
   prdata_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      acc_s ##0 pwrite |-> prdata == 32'h0) else $error("read data on write");
endmodule : smf_frame_checker
bind smf_frame_ctrl smf_frame_checker smf_frame_checker_inst (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .link_clk,
   .flash_io_in, .flash_io, .flash_clk_gate, .flash_select_line_n);

// ===== tb/smf_flash_model.sv
// Behavioural serial flash answering data-phase reads
`timescale 1ns/1ps
module smf_flash_model import smf_pkg::*; #(
   parameter logic [63:0] PAT = 64'h0
) (
   // Link clock and lines
   input wire logic link_clk,
   input wire logic sel_n,
   input wire logic gate,
   input wire smf_io_t io,
   // Read setup
   input wire logic quad,
   input wire logic [3:0] lead,
   // Lines driven back
   output logic [3:0] drv
);
   logic [63:0] pat; // Reply bits left
   logic [3:0] skip; // Undriven cycles passed
   initial drv = 4'h6;
   // Shift on falling flash clock, garble lines while idle
   always @(negedge link_clk) begin
      if (sel_n) begin
         pat <= PAT;
         skip <= 4'h0;
         drv <= ~drv;
      end else if (gate && io.oe == 4'h0) begin
         if (skip < lead) begin
            skip <= skip + 4'h1;
         end else begin
            drv <= quad ? pat[63:60] : {~pat[63], ~pat[63], pat[63], ~pat[63]};
            pat <= quad ? pat << 4 : pat << 1;
         end
      end
   end
endmodule : smf_flash_model

// ===== tb/test_spi_manual_frame_phases.sv
// Self-checking bench of the manual frame controller
`timescale 1ns/1ps
module test_spi_manual_frame_phases import smf_pkg::*; ;
   localparam logic [63:0] PAT = 64'ha5c3_96f0_1e2d_3c4b; // Flash reply
   localparam logic [31:0] CMD = 32'h00a1_005e; // Command bytes
   localparam logic [31:0] ADR = 32'h1234_5678; // Flash address
   localparam logic [31:0] OPT = 32'h9abc_def0; // Option bytes
   localparam logic [63:0] WD = 64'hc3c3_0f0f_5a5a_a5a5; // Write data
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic pready, pslverr, e, link_clk = 0, gate, sel_n, quad = 0, clr = 0;
   logic [3:0] lead = 4'h0, drv, io_in;
   smf_io_t io;
   logic [191:0] cap, exp; // Seen and expected line bits
   int ncyc, n_mismatch = 0, total_checks = 0, cyc = 0;
   // Clocks, link one offset in phase
   always #5 pclk = ~pclk;
   initial begin
      #7;
      forever #15 link_clk = ~link_clk;
   end
   // Wire level from both parties
   assign io_in = (io.oe & io.dout) | (~io.oe & drv);
   smf_frame_ctrl smf_frame_ctrl_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .link_clk, .flash_io_in(io_in), .flash_io(io),
      .flash_clk_gate(gate), .flash_select_line_n(sel_n));
   smf_flash_model #(.PAT(PAT)) smf_flash_model_inst (.link_clk, .sel_n, .gate, .io,
      .quad, .lead, .drv);
   // Count clocked cycles and collect driven bits mid-cycle
   always @(negedge link_clk) begin
      if (clr) begin
         cap = 0;
         ncyc = 0;
         clr = 0;
      end else if (gate) begin
         ncyc++;
         if (io.oe == 4'hf) begin
            cap = {cap[187:0], io.dout};
         end else if (io.oe == 4'h1) begin
            cap = {cap[190:0], io.dout[0]};
         end
      end
   end
   // Hang guard
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 30000) begin
         n_mismatch++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim
   task automatic check(input logic [191:0] seen, input logic [191:0] want);
      total_checks++;
      if (seen !== want) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : check
   // One APB transfer, held until pready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   function automatic smf_phase_cfg_t mkp(input logic [1:0] cw, ow, aw, pw, dw,
      input logic ce, oc, dm, input logic [3:0] ae, pe, de);
      return '{cw, ow, 2'b0, aw, 2'b0, pw, 2'b0, dw, dm, ce, 1'b0, oc, ae, pe, de};
   endfunction : mkp
   // Run one frame; c is {dummy count, ddr, write, read, hold}
   task automatic frame(input smf_phase_cfg_t p, input logic [6:0] c, input int n);
      logic [63:0] r;
      int len;
      len = p.data_en == 4'h8 ? 8 : p.data_en == 4'hc ? 16 : p.data_en == 4'hf ? 32 : 0;
      len = c[3] ? len * 2 : len;
      exp = 0;
      if (p.cmd_en) exp = {exp[183:0], CMD[23:16]};
      if (p.ocmd_en) exp = {exp[183:0], CMD[7:0]};
      if (p.addr_en == 4'h7) exp = {exp[167:0], ADR[23:0]};
      if (p.addr_en == 4'hf) exp = {exp[159:0], ADR};
      for (int i = 0; i < 4; i++) begin
         if (p.opt_en[3 - i]) exp = {exp[183:0], OPT[31 - 8 * i -: 8]};
      end
      if (c[2] && len > 0) exp = (exp << len) | 192'(WD >> (64 - len));
      apb(1'b1, 8'h04, p);
      clr = 1;
      apb(1'b1, 8'h00, {24'h0, c, 1'b1});
      repeat (12) @(posedge pclk);
      do apb(1'b0, 8'h00, 32'h0); while (q[16] !== 1'b0);
      check(cap, exp);
      check(192'(ncyc), 192'(n));
      check(192'(sel_n), 192'(!c[0]));
      if (c[1]) begin
         apb(1'b0, 8'h1c, 32'h0);
         r[63:32] = q;
         apb(1'b0, 8'h20, 32'h0);
         r[31:0] = q;
         check(192'(r), 192'((PAT >> (64 - len)) << (64 - len)));
      end
      $display("Frame done, %0d clocked cycles", ncyc);
   endtask : frame
   // Main sequence
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (20) @(posedge pclk);
      apb(1'b1, 8'h08, CMD);
      apb(1'b1, 8'h0c, ADR);
      apb(1'b1, 8'h10, OPT);
      apb(1'b1, 8'h14, WD[63:32]);
      apb(1'b1, 8'h18, WD[31:0]);
      apb(1'b0, 8'h26, 32'h0);
      check(192'({q, e}), 192'h1);
      $display("Unmapped access done");
      frame(mkp(2'b00, 2'b00, 2'b00, 2'b00, 2'b00, 1'b1, 1'b0, 1'b0, 4'h0, 4'h0, 4'h8), 7'h02, 16);
      frame(mkp(2'b10, 2'b00, 2'b10, 2'b00, 2'b10, 1'b1, 1'b1, 1'b0, 4'h7, 4'h8, 4'hc), 7'h05, 28);
      frame(mkp(2'b00, 2'b10, 2'b00, 2'b10, 2'b00, 1'b0, 1'b1, 1'b1, 4'hf, 4'hf, 4'hf),
         7'h7c, 114);
      quad <= 1'b1;
      lead <= 4'h3;
      frame(mkp(2'b00, 2'b00, 2'b00, 2'b10, 2'b10, 1'b1, 1'b0, 1'b1, 4'h7, 4'hc, 4'hf), 7'h22, 47);
      quad <= 1'b0;
      lead <= 4'h0;
      frame(mkp(2'b00, 2'b00, 2'b00, 2'b10, 2'b00, 1'b0, 1'b0, 1'b0, 4'h0, 4'he, 4'hc), 7'h0a, 38);
      frame(mkp(2'b00, 2'b00, 2'b00, 2'b00, 2'b00, 1'b0, 1'b0, 1'b0, 4'h3, 4'h0, 4'h8), 7'h00, 0);
      end_sim();
   end
endmodule : test_spi_manual_frame_phases
